// ===== design/pll_ctrl.sv
`timescale 1ns/10ps
module pll_ctrl
   import pll_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // link to the loop
   pll_link_if.ctl          link
);
   typedef enum {E_IDLE, E_CLR, E_LOW, E_HIGH} eng_e;

   logic [31:0]          word_q [NWORDS];
   logic                 sw_q, guard_q, done_q, lock_p_q;
   eng_e                 eng_q;
   logic [7:0]           div_q, idx_q;
   logic [NWORDS*32-1:0] flat;
   logic                 wr, rd_setup, busy, hit_chain;
   logic [31:0]          rd_d;

   assign wr        = psel & penable & pwrite;
   assign rd_setup  = psel & ~penable;
   assign busy      = (eng_q != E_IDLE);
   assign hit_chain = (paddr >= OFS_CHAIN) &&
                      (paddr < OFS_CHAIN + 8'(4 * NWORDS)) &&
                      (paddr[1:0] == 2'b00);
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~(hit_chain ||
                      paddr == OFS_CTRL || paddr == OFS_STATUS);

   always_comb begin
      flat = '0;
      for (int w = 0; w < NWORDS; w++)
         flat[w*32 +: 32] = word_q[w];
   end

   // read data taken in setup so it stands in the access cycle
   always_comb begin
      rd_d = 32'h0;
      if (paddr == OFS_CTRL) begin
         rd_d[C_SWITCH] = sw_q;
         rd_d[C_GUARD]  = guard_q;
      end else if (paddr == OFS_STATUS) begin
         rd_d[S_BUSY] = busy;
         rd_d[S_LOCK] = link.locked;
         rd_d[S_SEL]  = link.ref_sel;
         rd_d[S_DONE] = done_q;
      end else if (hit_chain) begin
         rd_d = word_q[3'((paddr - OFS_CHAIN) >> 2)];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h0;
      else if (rd_setup && !pwrite)
         prdata <= rd_d;
   end

   // chain image; ignored while a shift is running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int w = 0; w < NWORDS; w++)
            word_q[w] <= 32'h0;
      end else if (wr && hit_chain && !busy) begin
         word_q[3'((paddr - OFS_CHAIN) >> 2)] <= pwdata;
      end
   end

   // switch request level; lock loss under guard sets it, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_q     <= 1'b0;
         guard_q  <= 1'b0;
         lock_p_q <= 1'b0;
      end else begin
         lock_p_q <= link.locked;
         if (wr && paddr == OFS_CTRL) begin
            sw_q    <= pwdata[C_SWITCH];
            guard_q <= pwdata[C_GUARD];
         end
         if (guard_q && lock_p_q && !link.locked && !busy)
            sw_q <= 1'b1;
      end
   end
   assign link.switch_req = sw_q;

   // shift engine: clear, then CHAIN_LEN bits msb first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eng_q  <= E_IDLE;
         div_q  <= '0;
         idx_q  <= '0;
         done_q <= 1'b0;
      end else begin
         div_q <= (div_q == 8'(SHIFT_HALF - 1)) ? '0 : div_q + 8'h01;
         unique case (eng_q)
            E_IDLE: begin
               div_q <= '0;
               if (wr && paddr == OFS_CTRL && pwdata[C_GO]) begin
                  eng_q  <= E_CLR;
                  done_q <= 1'b0;
               end
            end
            E_CLR:
               if (div_q == 8'(SHIFT_HALF - 1)) begin
                  eng_q <= E_LOW;
                  idx_q <= 8'(CHAIN_LEN - 1);
               end
            E_LOW:
               if (div_q == 8'(SHIFT_HALF - 1))
                  eng_q <= E_HIGH;
            E_HIGH:
               if (div_q == 8'(SHIFT_HALF - 1)) begin
                  if (idx_q == 8'h00) begin
                     eng_q  <= E_IDLE;
                     done_q <= 1'b1;
                  end else begin
                     eng_q <= E_LOW;
                     idx_q <= idx_q - 8'h01;
                  end
               end
         endcase
      end
   end

   assign link.shift_clr_n = (eng_q != E_CLR);
   assign link.shift_clk   = (eng_q == E_HIGH);
   assign link.shift_data  = busy ? flat[idx_q] : 1'b0;
endmodule : pll_ctrl

// ===== design/pll_device.sv
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
// Functional notes
// - one n and one m, each 1..512
// - 2 regional, 4 global, 4 external post-dividers
// - non-50% duty limits divider to 512
// - reference divided by n, loop targets m/n
// - every output has its own post-divider
// - absent primary triggers automatic switch
// - state machine drives reference select
// - manual switch request honoured in SW_PRI and SW_SEC; a request rising during SW_WAIT is ignored
// - far logic switches refs beyond 20%
// - select changes glitch-free, oscillator runs
// - lock regained within 100 us
// - far logic may pair lock with request
// - chain shifted on its own shift clock
// - full chain loaded after last bit
// - asynchronous clear empties shift chain
// - reconfiguration under 20 us at 22 MHz
// - only counters and delays reconfigurable
// - each output has programmable delay
// - bandwidth 200 kHz to 1.5 MHz, fixed
// - first pin primary, second pin secondary
// - external outputs only on larger loops
module pll_device
   import pll_pkg::*;
#(
   parameter int RELOCK_CYC = RELOCK_DEF,
   parameter int SENSE_CYC  = SENSE_DEF,
   parameter bit LARGE_LOOP = 1'b1
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // link to the controlling logic
   pll_link_if.dev               link,
   // reference pins, first and second of the pair
   input  wire logic             primary_ref_input,
   input  wire logic             secondary_ref_input,
   // loop side
   output logic [NPOST-1:0]      clk_out,
   output logic                  ref_div_pulse,
   output logic [CNT_W-1:0]      fb_mult,
   output logic [CNT_W-1:0]      pre_div
);
   localparam int NS = 5;
   localparam int I_PRI = 0;
   localparam int I_SEC = 1;
   localparam int I_SW  = 2;
   localparam int I_SD  = 3;
   localparam int I_SCK = 4;

   typedef enum {SW_PRI, SW_WAIT, SW_SEC} sw_e;

   logic [NS-1:0]        sy1_q, sy2_q, sy3_q, lvl_q, lvl_p_q;
   logic [NS-1:0]        lvl_d, rise;
   logic [CHAIN_LEN-1:0] chain_q, act_q;
   logic [7:0]           bits_q;
   logic                 load_q;
   sw_e                  sw_q;
   logic                 sel_q, ref_q, want_q;
   logic [15:0]          sense_q;
   logic                 absent;
   logic [31:0]          relock_q;
   logic [CNT_W-1:0]     ndiv_q;
   wire                  chain_rst_n = presetn & link.shift_clr_n;

   // three-stage sampling of every pin from outside pclk except the chain clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sy1_q   <= '0;
         sy2_q   <= '0;
         sy3_q   <= '0;
         lvl_q   <= '0;
         lvl_p_q <= '0;
      end else begin
         sy1_q   <= {link.shift_clk, link.shift_data, link.switch_req,
                     secondary_ref_input, primary_ref_input};
         sy2_q   <= sy1_q;
         sy3_q   <= sy2_q;
         lvl_q   <= lvl_d;
         lvl_p_q <= lvl_q;
      end
   end

   // a level moves only once stages two and three agree
   always_comb begin
      lvl_d = (sy2_q & ~(sy2_q ^ sy3_q)) | (lvl_q & (sy2_q ^ sy3_q));
      rise  = lvl_q & ~lvl_p_q;
   end

   // serial chain on shift-clock edges; clear acts at once
   always_ff @(posedge pclk or negedge chain_rst_n) begin
      if (!chain_rst_n) begin
         chain_q <= '0;
         bits_q  <= '0;
         load_q  <= 1'b0;
      end else begin
         load_q <= 1'b0;
         if (rise[I_SCK]) begin
            chain_q <= {chain_q[CHAIN_LEN-2:0], lvl_q[I_SD]};
            if (bits_q == 8'(CHAIN_LEN - 1)) begin
               bits_q <= '0;
               load_q <= 1'b1;
            end else begin
               bits_q <= bits_q + 8'h01;
            end
         end
      end
   end

   // active set changes only on the load pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         act_q <= cfg_reset();
      else if (load_q)
         act_q <= chain_q;
   end

   // clock sense: primary absent after SENSE_CYC quiet cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sense_q <= '0;
      else if (rise[I_PRI] || lvl_q[I_PRI] != lvl_p_q[I_PRI])
         sense_q <= '0;
      else if (!absent)
         sense_q <= sense_q + 16'h0001;
   end
   assign absent = (sense_q >= 16'(SENSE_CYC));

   // switchover machine; select moves only while the secondary is low and the primary low or absent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_q   <= SW_PRI;
         sel_q  <= 1'b0;
         want_q <= 1'b0;
      end else begin
         unique case (sw_q)
            SW_PRI, SW_SEC: begin
               if (rise[I_SW]) begin
                  want_q <= ~sel_q;
                  sw_q   <= SW_WAIT;
               end else if (sw_q == SW_PRI && absent) begin
                  want_q <= 1'b1;
                  sw_q   <= SW_WAIT;
               end
            end
            SW_WAIT: begin
               // an absent primary may idle high, so count it as low
               if ((!lvl_q[I_PRI] || absent) && !lvl_q[I_SEC]) begin
                  sel_q <= want_q;
                  sw_q  <= want_q ? SW_SEC : SW_PRI;
               end
            end
         endcase
      end
   end

   // selected reference and n divider on its rising edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_q         <= 1'b0;
         ndiv_q        <= '0;
         ref_div_pulse <= 1'b0;
      end else begin
         ref_q         <= sel_q ? lvl_q[I_SEC] : lvl_q[I_PRI];
         ref_div_pulse <= 1'b0;
         if ((sel_q ? lvl_q[I_SEC] : lvl_q[I_PRI]) && !ref_q) begin
            if ({1'b0, ndiv_q} + 11'h001 >=
                eff_div(act_q[POS_N +: CNT_W], 1'b0)) begin
               ndiv_q        <= '0;
               ref_div_pulse <= 1'b1;
            end else begin
               ndiv_q <= ndiv_q + 10'h001;
            end
         end
      end
   end

   // lock model: lost on switch or load, back after RELOCK_CYC
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         relock_q <= '0;
      else if (load_q || sw_q == SW_WAIT)
         relock_q <= '0;
      else if (relock_q < 32'(RELOCK_CYC))
         relock_q <= relock_q + 32'h1;
   end

   assign link.locked  = (relock_q >= 32'(RELOCK_CYC));
   assign link.ref_sel = sel_q;
   assign fb_mult      = act_q[POS_M +: CNT_W];
   assign pre_div      = act_q[POS_N +: CNT_W];

   // one post-divider and delay line per output, loop as oscillator
   for (genvar i = 0; i < NPOST; i++) begin : g_post
      localparam int B = POS_POST + i * FIELD_W;
      logic [CNT_W:0]    cnt_q, div;
      logic [DLY_TAPS-1:0] hist_q;
      logic              duty, raw;
      assign duty = act_q[B + F_DUTY];
      assign div  = eff_div(act_q[B + F_CNT +: CNT_W], duty);
      // 50% holds high for the lower half, otherwise one cycle
      assign raw  = duty ? (cnt_q < ((div + 11'h001) >> 1))
                         : (cnt_q == '0);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cnt_q      <= '0;
            hist_q     <= '0;
            clk_out[i] <= 1'b0;
         end else begin
            cnt_q  <= (cnt_q + 11'h001 >= div) ? '0 : cnt_q + 11'h001;
            hist_q <= {hist_q[DLY_TAPS-2:0], raw};
            if (!LARGE_LOOP && i >= EXT0)
               clk_out[i] <= 1'b0;
            else
               clk_out[i] <= hist_q[act_q[B + F_DLY +: DLY_W]];
         end
      end
   end
endmodule : pll_device

// ===== include/pll_link_if.sv
`timescale 1ns/10ps
interface pll_link_if;
   logic switch_req;
   logic shift_clk;
   logic shift_data;
   logic shift_clr_n;
   logic locked;
   logic ref_sel;
   modport dev (input switch_req, shift_clk, shift_data, shift_clr_n,
                output locked, ref_sel);
   modport ctl (output switch_req, shift_clk, shift_data, shift_clr_n,
                input locked, ref_sel);
endinterface : pll_link_if

// ===== include/pll_pkg.sv
package pll_pkg;
   // counter, chain and delay layout
   localparam int CNT_W     = 10;
   localparam int NM_MAX    = 512;
   localparam int POST_MAX  = 1024;
   localparam int N_REG     = 2;
   localparam int N_GLB     = 4;
   localparam int N_EXT     = 4;
   localparam int NPOST     = N_REG + N_GLB + N_EXT;
   localparam int GLB0      = N_REG;
   localparam int EXT0      = N_REG + N_GLB;
   localparam int DLY_W     = 3;
   localparam int DLY_TAPS  = 8;
   localparam int F_CNT     = 0;
   localparam int F_DUTY    = CNT_W;
   localparam int F_DLY     = CNT_W + 1;
   localparam int FIELD_W   = CNT_W + 1 + DLY_W;
   localparam int POS_N     = 0;
   localparam int POS_M     = CNT_W;
   localparam int POS_POST  = 2 * CNT_W;
   localparam int CHAIN_LEN = POS_POST + NPOST * FIELD_W;
   localparam int NWORDS    = (CHAIN_LEN + 31) / 32;
   // timing, pclk at 250 MHz
   localparam int T_CLK_PS   = 4000;
   localparam int RELOCK_US  = 100;
   localparam int RELOCK_DEF = RELOCK_US * 1000000 / T_CLK_PS;
   localparam int RECFG_US   = 20;
   localparam int SHIFT_KHZ  = 22000;
   // half period rounded up so the shift clock never beats 22 MHz
   localparam int SHIFT_HALF =
      (1000000000 / SHIFT_KHZ + 2 * T_CLK_PS - 1) / (2 * T_CLK_PS);
   localparam int RECFG_CYC  = RECFG_US * 1000000 / T_CLK_PS;
   localparam int SENSE_DEF  = 64;
   // register map of the controller
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CHAIN  = 8'h10;
   localparam int C_SWITCH = 0;
   localparam int C_GO     = 1;
   localparam int C_GUARD  = 2;
   localparam int S_BUSY   = 0;
   localparam int S_LOCK   = 1;
   localparam int S_SEL    = 2;
   localparam int S_DONE   = 3;

   // divide value 1..1024, capped at 512 unless half is set; code 0 stands for 1024
   function automatic logic [CNT_W:0] eff_div(logic [CNT_W-1:0] c,
                                              logic half);
      logic [CNT_W:0] v;
      v = (c == '0) ? (CNT_W+1)'(POST_MAX) : {1'b0, c};
      if (!half && v > (CNT_W+1)'(NM_MAX))
         v = (CNT_W+1)'(NM_MAX);
      return v;
   endfunction : eff_div

   // reset image: all dividers 1, 50% duty, no delay
   function automatic logic [CHAIN_LEN-1:0] cfg_reset();
      logic [CHAIN_LEN-1:0] r;
      r = '0;
      r[POS_N] = 1'b1;
      r[POS_M] = 1'b1;
      for (int i = 0; i < NPOST; i++) begin
         r[POS_POST + i*FIELD_W + F_CNT]  = 1'b1;
         r[POS_POST + i*FIELD_W + F_DUTY] = 1'b1;
      end
      return r;
   endfunction : cfg_reset
endpackage : pll_pkg

// ===== tb/pll_link_props.sv
`timescale 1ns/10ps
module pll_link_props #(
   parameter int RELOCK_CYC = 20
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link between controller and loop
   input wire logic switch_req,
   input wire logic shift_clk,
   input wire logic shift_data,
   input wire logic shift_clr_n,
   input wire logic locked,
   input wire logic ref_sel
);
   // slack of two cycles for the registered lock compare
   localparam int RL_MAX = RELOCK_CYC + 2;

   logic [7:0] rises_q;
   logic       clk_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // previous shift clock level for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) clk_q <= 1'b0;
      else          clk_q <= shift_clk;
   end

   // shift clock rises since the last clear, to spot the final bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)                rises_q <= 8'h00;
      else if (!shift_clr_n)       rises_q <= 8'h00;
      else if (shift_clk && !clk_q) rises_q <= rises_q + 8'h01;
   end

   a_sel_unlocked: assert property ($changed(ref_sel) |-> !locked)
      else $error("reference changed while lock was shown");
   a_relock_time: assert property (
      $changed(ref_sel) |-> ##[1:RL_MAX] locked)
      else $error("lock not regained in time after switch");
   a_req_unlock: assert property (
      $rose(switch_req) && locked |-> ##[1:8] !locked)
      else $error("switch request not taken up");
   a_data_hold: assert property (shift_clk |-> $stable(shift_data))
      else $error("shift data moved while shift clock high");
   a_clk_high: assert property (
      $rose(shift_clk) |-> shift_clk [*6] ##1 !shift_clk)
      else $error("shift clock high phase wrong length");
   a_clk_low: assert property ($fell(shift_clk) |-> !shift_clk [*6])
      else $error("shift clock low phase too short");
   a_clear_width: assert property (
      $fell(shift_clr_n) |-> !shift_clr_n [*6] ##1 shift_clr_n)
      else $error("chain clear wrong length");
   a_clear_idle: assert property (!shift_clr_n |-> !shift_clk)
      else $error("shift clock toggled during clear");
   a_first_bit: assert property (
      $rose(shift_clr_n) |-> !shift_clk [*6] ##1 shift_clk)
      else $error("first bit not one low phase after clear");
   a_load_relock: assert property (
      $rose(shift_clk) && rises_q == 8'h9f |-> ##[2:8] !locked)
      else $error("full chain did not load");

   c_switch: cover property ($changed(ref_sel));
   c_last_bit: cover property ($rose(shift_clk) && rises_q == 8'h9f);
   c_request: cover property ($rose(switch_req));
endmodule : pll_link_props

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench
   import pll_pkg::*;
;
   logic               pclk;
   logic               presetn;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [7:0]         paddr;
   logic [31:0]        pwdata;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   logic               prim;
   logic               sec;
   logic               prim_run;
   logic               ref_div_pulse;
   logic [NPOST-1:0]   clk_out;
   logic [CNT_W-1:0]   fb_mult;
   logic [CNT_W-1:0]   pre_div;
   logic [31:0]        rd;
   logic               er;
   int                 fail_count;
   int                 cmp_count;
   int                 cyc;
   int                 rcnt;

   pll_link_if pll_link_if_i ();

   pll_device #(.RELOCK_CYC(20), .SENSE_CYC(16)) pll_device_i (
      .pclk(pclk), .presetn(presetn), .link(pll_link_if_i),
      .primary_ref_input(prim), .secondary_ref_input(sec),
      .clk_out(clk_out), .ref_div_pulse(ref_div_pulse),
      .fb_mult(fb_mult), .pre_div(pre_div));

   pll_ctrl pll_ctrl_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(pll_link_if_i));

   pll_link_props #(.RELOCK_CYC(20)) pll_link_props_i (
      .pclk(pclk), .presetn(presetn),
      .switch_req(pll_link_if_i.switch_req),
      .shift_clk(pll_link_if_i.shift_clk),
      .shift_data(pll_link_if_i.shift_data),
      .shift_clr_n(pll_link_if_i.shift_clr_n),
      .locked(pll_link_if_i.locked), .ref_sel(pll_link_if_i.ref_sel));

   // 250 MHz
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // references 25% apart, beyond what clock sense can follow
   always @(posedge pclk) begin
      rcnt <= rcnt + 1;
      if (prim_run && rcnt % 4 == 3) prim <= ~prim;
      if (rcnt % 5 == 4) sec <= ~sec;
   end

   // hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results

   // one apb transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic t_idle();
      repeat (40) @(posedge pclk);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h2);
      chk(32'(pre_div), 32'h1);
      chk(32'(fb_mult), 32'h1);
      apb(1'b0, 8'h40, 32'h0);
      chk(32'(er), 32'h1);
      chk(rd, 32'h0);
   endtask : t_idle

   // counts from one rising edge of an output to the next
   task automatic per(input int i, input int exp);
      int  c;
      logic p;
      c = 0;
      do begin
         p = clk_out[i];
         @(posedge pclk);
         #1;
      end while (!(clk_out[i] === 1'b1 && p === 1'b0));
      do begin
         p = clk_out[i];
         @(posedge pclk);
         #1;
         c++;
      end while (!(clk_out[i] === 1'b1 && p === 1'b0));
      chk(32'(c), 32'(exp));
   endtask : per

   // output 4 runs two taps behind output 5, same divider
   task automatic t_delay();
      int  c;
      logic p;
      c = 0;
      do begin
         p = clk_out[5];
         @(posedge pclk);
      end while (!(clk_out[5] === 1'b1 && p === 1'b0));
      do begin
         p = clk_out[4];
         @(posedge pclk);
         c++;
      end while (!(clk_out[4] === 1'b1 && p === 1'b0));
      chk(32'(c), 32'h2);
   endtask : t_delay

   // n of 5 on a primary of 8 cycles gives one pulse per 40
   task automatic t_ndiv();
      int c;
      c = 0;
      while (ref_div_pulse !== 1'b1)
         @(posedge pclk);
      do begin
         @(posedge pclk);
         c++;
      end while (ref_div_pulse !== 1'b1);
      chk(32'(c), 32'h28);
   endtask : t_ndiv

   // a load drops lock; with guard set that raises the request
   task automatic t_guard();
      prim_run <= 1'b1;
      apb(1'b1, OFS_CTRL, 32'h6);
      for (int k = 0; k < 3000 && pll_link_if_i.ref_sel !== 1'b0; k++)
         @(posedge pclk);
      chk(32'(pll_link_if_i.ref_sel), 32'h0);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h5);
   endtask : t_guard

   task automatic t_reconfig();
      logic [CHAIN_LEN-1:0] img;
      img = '0;
      img[9:0] = 10'h005;
      img[19:10] = 10'h007;
      for (int i = 0; i < NPOST; i++)
         img[POS_POST + i*FIELD_W +: FIELD_W] = 14'h0401;
      img[POS_POST +: FIELD_W] = 14'h0403;
      img[POS_POST + FIELD_W +: FIELD_W] = 14'h0258;
      img[POS_POST + 2*FIELD_W +: FIELD_W] = 14'h0400;
      img[POS_POST + 3*FIELD_W +: FIELD_W] = 14'h0004;
      img[POS_POST + 4*FIELD_W +: FIELD_W] = 14'h1408;
      img[POS_POST + 5*FIELD_W +: FIELD_W] = 14'h0408;
      for (int w = 0; w < NWORDS; w++)
         apb(1'b1, OFS_CHAIN + 8'(4*w), img[32*w +: 32]);
      apb(1'b1, OFS_CTRL, 32'h2);
      repeat (100) @(posedge pclk);
      chk(32'(pre_div), 32'h1);
      apb(1'b1, OFS_CHAIN, 32'h9);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(32'(rd[0]), 32'h1);
      for (int k = 0; k < 2000 && rd[3] !== 1'b1; k++)
         apb(1'b0, OFS_STATUS, 32'h0);
      repeat (8) @(posedge pclk);
      chk(32'(pre_div), 32'h5);
      chk(32'(fb_mult), 32'h7);
      per(0, 3);
      per(1, 512);
      per(2, 1024);
      per(3, 4);
      t_delay();
      t_ndiv();
   endtask : t_reconfig

   // a rising edge of the request flips the reference
   task automatic sw_to(input logic s);
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h1);
      for (int k = 0; k < 200 && pll_link_if_i.ref_sel !== s; k++)
         @(posedge pclk);
      chk(32'(pll_link_if_i.ref_sel), 32'(s));
      repeat (40) @(posedge pclk);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(32'(rd[2:1]), {30'h0, s, 1'b1});
   endtask : sw_to

   task automatic t_auto();
      prim_run <= 1'b0;
      for (int k = 0; k < 200 && pll_link_if_i.ref_sel !== 1'b1; k++)
         @(posedge pclk);
      chk(32'(pll_link_if_i.ref_sel), 32'h1);
      repeat (40) @(posedge pclk);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(32'(rd[2:1]), 32'h3);
   endtask : t_auto

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      prim = 1'b0;
      sec = 1'b0;
      prim_run = 1'b1;
      fail_count = 0;
      cmp_count = 0;
      cyc = 0;
      rcnt = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_idle();
      t_reconfig();
      sw_to(1'b1);
      sw_to(1'b0);
      t_auto();
      t_guard();
      results();
   end
endmodule : testbench
